// ===== rtl/cpuxfr_core.sv
// Execution core for trap, transfer, test, wait and operand addressing modes
// Summary of operation
// - The software trap takes nine cycles, steps the PC, pushes PC low, PC high, X, A and flags, sets I and loads the vector.
// - The test op checks A, X or memory minus zero, sets N and Z, clears V, and keeps C, H and I.
// - Wait is a one-cycle inherent op that clears only the interrupt mask.
// - After wait the core halts until an interrupt request arrives and then resumes.
// - Direct-to-indexed moves read a direct byte, write it at H:X and then step H:X.
// - Indexed-to-direct moves read at H:X, step H:X, and then write to the direct address.
// - Immediate-to-direct moves write the immediate byte to the direct address in the next byte.
// - Offset post-increment indexing addresses H:X plus an 8-bit offset and steps H:X afterwards.
// - Long offset indexing fetches a 16-bit offset high byte first and adds it to H:X.
// - Extended addressing fetches a 16-bit address high byte first.
// - Stack short offset addresses SP plus an 8-bit offset byte.
// - Bit test branches carry a direct address then a signed offset added to the PC when taken.
`timescale 1ns/10ps
`default_nettype none
`include "cpuxfr_defs.svh"
module cpuxfr_core #(
    parameter logic [15:0] VECTOR_ADDR = 16'hfffc
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Memory bus
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Interrupt and status
    input wire logic irq_req,
    output logic halted,
    output logic [7:0] condition_code_register
);
    cpuxfr_pkg::cpuxfr_state_t state, next_state;
    logic [15:0] pc, next_pc, sp, next_sp, hx, next_hx, ea, next_ea;
    logic [7:0] acc, next_acc, flg, next_flg, op, next_op, pre, next_pre, tmp, next_tmp;
    logic [3:0] cnt, next_cnt;
    logic [15:0] next_mem_addr;
    logic next_mem_rd, next_mem_wr, next_halted;
    logic [7:0] next_mem_wdata;

    // Flags for a tested value; C, H and I kept
    function automatic logic [7:0] test_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[`CPUXFR_BIT_V] = 1'b0;
        r[`CPUXFR_BIT_N] = v[7];
        r[`CPUXFR_BIT_Z] = (v == 8'h00);
        return r;
    endfunction

    // Number of operand bytes after the opcode
    function automatic logic [1:0] opnd_len(input logic [7:0] p, input logic [7:0] o);
        if (p == `CPUXFR_OP_PRE) begin
            return 2'd1;
        end
        case (o)
            `CPUXFR_OP_TSTD, `CPUXFR_OP_TSTIX1, `CPUXFR_OP_MOVDIX: return 2'd1;
            `CPUXFR_OP_MOVIMD, `CPUXFR_OP_LDAEXT, `CPUXFR_OP_LDAIX2, `CPUXFR_OP_CBEQIX1P: return 2'd2;
            `CPUXFR_OP_BRSET0: return 2'd2;
            default: return 2'd0;
        endcase
    endfunction

    // =========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_sp = sp;
        next_hx = hx;
        next_ea = ea;
        next_acc = acc;
        next_flg = flg;
        next_op = op;
        next_pre = pre;
        next_tmp = tmp;
        next_cnt = cnt;
        next_mem_addr = mem_addr;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
        next_mem_wdata = mem_wdata;
        next_halted = 1'b0;
        case (state)
            cpuxfr_pkg::CPUXFR_FETCH: begin
                // Opcode data returns the next cycle, while the registered read strobe is high
                next_mem_addr = pc;
                next_mem_rd = 1'b1;
                next_pc = pc + 16'h0001;
                next_cnt = 4'h0;
                next_state = cpuxfr_pkg::CPUXFR_EXEC;
            end
            cpuxfr_pkg::CPUXFR_EXEC: begin
                next_op = mem_rdata;
                next_state = cpuxfr_pkg::CPUXFR_FETCH;
                case (mem_rdata)
                    `CPUXFR_OP_PRE: begin
                        next_pre = mem_rdata;
                        next_mem_addr = pc;
                        next_mem_rd = 1'b1;
                        next_pc = pc + 16'h0001;
                        next_state = cpuxfr_pkg::CPUXFR_EXEC;
                    end
                    `CPUXFR_OP_TRAP: begin
                        next_pc = pc + 16'h0001;
                        next_cnt = 4'h0;
                        next_state = cpuxfr_pkg::CPUXFR_PUSH;
                    end
                    `CPUXFR_OP_TAP: begin
                        next_flg = acc;
                        next_state = cpuxfr_pkg::CPUXFR_HALT;
                        next_cnt = 4'h1;
                    end
                    `CPUXFR_OP_FLG2A: next_acc = flg;
                    `CPUXFR_OP_A2X: next_hx = {hx[15:8], acc};
                    `CPUXFR_OP_X2A: next_acc = hx[7:0];
                    `CPUXFR_OP_SP2X: begin
                        next_hx = sp + 16'h0001;
                        next_state = cpuxfr_pkg::CPUXFR_HALT;
                        next_cnt = 4'h1;
                    end
                    `CPUXFR_OP_X2SP: begin
                        next_sp = hx - 16'h0001;
                        next_state = cpuxfr_pkg::CPUXFR_HALT;
                        next_cnt = 4'h1;
                    end
                    `CPUXFR_OP_TSTA: next_flg = test_flags(flg, acc);
                    `CPUXFR_OP_TSTX: next_flg = test_flags(flg, hx[7:0]);
                    `CPUXFR_OP_TSTIX: begin
                        next_ea = hx;
                        next_mem_addr = hx;
                        next_mem_rd = 1'b1;
                        next_state = cpuxfr_pkg::CPUXFR_READ;
                    end
                    `CPUXFR_OP_MOVIXD: begin
                        next_ea = hx;
                        next_mem_addr = hx;
                        next_mem_rd = 1'b1;
                        next_state = cpuxfr_pkg::CPUXFR_READ;
                    end
                    `CPUXFR_OP_WAIT: begin
                        next_flg[`CPUXFR_BIT_I] = 1'b0;
                        next_halted = 1'b1;
                        next_state = cpuxfr_pkg::CPUXFR_HALT;
                        next_cnt = 4'h0;
                    end
                    default: begin
                        if (opnd_len(pre, mem_rdata) != 2'd0) begin
                            next_mem_addr = pc;
                            next_mem_rd = 1'b1;
                            next_pc = pc + 16'h0001;
                            next_state = cpuxfr_pkg::CPUXFR_OPND;
                        end else begin
                            next_pre = 8'h00;
                        end
                    end
                endcase
            end
            cpuxfr_pkg::CPUXFR_OPND: begin
                // cnt 0: first operand byte, cnt 1: second
                if (cnt == 4'h0) begin
                    next_tmp = mem_rdata;
                    if (opnd_len(pre, op) == 2'd2) begin
                        next_cnt = 4'h1;
                        next_mem_addr = pc;
                        next_mem_rd = 1'b1;
                        next_pc = pc + 16'h0001;
                    end else begin
                        if (pre == `CPUXFR_OP_PRE) begin
                            next_ea = sp + {8'h00, mem_rdata};
                        end else if (op == `CPUXFR_OP_TSTIX1) begin
                            next_ea = hx + {8'h00, mem_rdata};
                        end else begin
                            next_ea = {8'h00, mem_rdata};
                        end
                        next_mem_addr = next_ea;
                        next_mem_rd = 1'b1;
                        next_state = cpuxfr_pkg::CPUXFR_READ;
                    end
                end else begin
                    next_cnt = 4'h0;
                    next_mem_rd = 1'b1;
                    next_state = cpuxfr_pkg::CPUXFR_READ;
                    case (op)
                        `CPUXFR_OP_LDAEXT: next_ea = {tmp, mem_rdata};
                        `CPUXFR_OP_LDAIX2: next_ea = hx + {tmp, mem_rdata};
                        `CPUXFR_OP_CBEQIX1P: next_ea = hx + {8'h00, tmp};
                        `CPUXFR_OP_BRSET0: begin
                            next_ea = {8'h00, tmp};
                            next_tmp = mem_rdata;
                        end
                        default: begin
                            // Immediate to direct: no source read needed
                            next_ea = {8'h00, mem_rdata};
                            next_mem_rd = 1'b0;
                            next_mem_addr = {8'h00, mem_rdata};
                            next_mem_wdata = tmp;
                            next_mem_wr = 1'b1;
                            next_state = cpuxfr_pkg::CPUXFR_FETCH;
                        end
                    endcase
                    if (next_mem_rd) begin
                        next_mem_addr = next_ea;
                    end
                end
            end
            cpuxfr_pkg::CPUXFR_READ: begin
                next_state = cpuxfr_pkg::CPUXFR_FETCH;
                next_pre = 8'h00;
                case (op)
                    `CPUXFR_OP_MOVDIX: begin
                        next_mem_addr = hx;
                        next_mem_wdata = mem_rdata;
                        next_mem_wr = 1'b1;
                        next_hx = hx + 16'h0001;
                    end
                    `CPUXFR_OP_MOVIXD: begin
                        next_state = cpuxfr_pkg::CPUXFR_WRITE;
                        next_tmp = mem_rdata;
                        next_hx = hx + 16'h0001;
                        next_mem_addr = pc;
                        next_mem_rd = 1'b1;
                        next_pc = pc + 16'h0001;
                    end
                    `CPUXFR_OP_LDAEXT, `CPUXFR_OP_LDAIX2: next_acc = mem_rdata;
                    `CPUXFR_OP_CBEQIX1P: begin
                        next_hx = hx + 16'h0001;
                        next_flg = test_flags(flg, acc - mem_rdata);
                    end
                    `CPUXFR_OP_BRSET0: begin
                        next_flg[`CPUXFR_BIT_C] = mem_rdata[0];
                        if (mem_rdata[0]) begin
                            next_pc = pc + {{8{tmp[7]}}, tmp};
                        end
                    end
                    default: next_flg = test_flags(flg, mem_rdata);
                endcase
            end
            cpuxfr_pkg::CPUXFR_WRITE: begin
                next_mem_addr = {8'h00, mem_rdata};
                next_mem_wdata = tmp;
                next_mem_wr = 1'b1;
                next_state = cpuxfr_pkg::CPUXFR_FETCH;
            end
            cpuxfr_pkg::CPUXFR_PUSH: begin
                // Five pushes, cycles 2 to 6 of the trap
                next_mem_addr = sp;
                next_mem_wr = 1'b1;
                next_sp = sp - 16'h0001;
                next_cnt = cnt + 4'h1;
                case (cnt)
                    4'h0: next_mem_wdata = pc[7:0];
                    4'h1: next_mem_wdata = pc[15:8];
                    4'h2: next_mem_wdata = hx[7:0];
                    4'h3: next_mem_wdata = acc;
                    default: begin
                        next_mem_wdata = flg;
                        next_flg[`CPUXFR_BIT_I] = 1'b1;
                        next_cnt = 4'h0;
                        next_state = cpuxfr_pkg::CPUXFR_VEC;
                    end
                endcase
            end
            cpuxfr_pkg::CPUXFR_VEC: begin
                next_cnt = cnt + 4'h1;
                case (cnt)
                    4'h0: begin
                        next_mem_addr = VECTOR_ADDR;
                        next_mem_rd = 1'b1;
                    end
                    4'h1: begin
                        next_pc = {mem_rdata, pc[7:0]};
                        next_mem_addr = VECTOR_ADDR + 16'h0001;
                        next_mem_rd = 1'b1;
                    end
                    default: begin
                        next_pc = {pc[15:8], mem_rdata};
                        next_state = cpuxfr_pkg::CPUXFR_FETCH;
                    end
                endcase
            end
            cpuxfr_pkg::CPUXFR_HALT: begin
                // Stretch cycle for two-cycle ops, or wait for interrupt
                if (cnt == 4'h1) begin
                    next_state = cpuxfr_pkg::CPUXFR_FETCH;
                end else if (irq_req) begin
                    next_state = cpuxfr_pkg::CPUXFR_FETCH;
                end else begin
                    next_halted = 1'b1;
                end
            end
            default: next_state = cpuxfr_pkg::CPUXFR_FETCH;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= cpuxfr_pkg::CPUXFR_FETCH;
            pc <= 16'h0000;
            sp <= `CPUXFR_SP_RST;
            hx <= 16'h0000;
            ea <= 16'h0000;
            acc <= 8'h00;
            flg <= `CPUXFR_FLG_RST;
            op <= 8'h00;
            pre <= 8'h00;
            tmp <= 8'h00;
            cnt <= 4'h0;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            halted <= 1'b0;
            condition_code_register <= `CPUXFR_FLG_RST;
        end else begin
            state <= next_state;
            pc <= next_pc;
            sp <= next_sp;
            hx <= next_hx;
            ea <= next_ea;
            acc <= next_acc;
            flg <= next_flg;
            op <= next_op;
            pre <= next_pre;
            tmp <= next_tmp;
            cnt <= next_cnt;
            mem_addr <= next_mem_addr;
            mem_rd <= next_mem_rd;
            mem_wr <= next_mem_wr;
            mem_wdata <= next_mem_wdata;
            halted <= next_halted;
            condition_code_register <= next_flg;
        end
    end
endmodule // cpuxfr_core
`default_nettype wire

// ===== rtl/cpuxfr_defs.svh
// Constants for the transfer, test and wait instruction core
`ifndef CPUXFR_DEFS_SVH
`define CPUXFR_DEFS_SVH
`define CPUXFR_OP_TRAP 8'h83
`define CPUXFR_OP_TAP 8'h84
`define CPUXFR_OP_FLG2A 8'h85
`define CPUXFR_OP_X2SP 8'h94
`define CPUXFR_OP_SP2X 8'h95
`define CPUXFR_OP_A2X 8'h97
`define CPUXFR_OP_X2A 8'h9f
`define CPUXFR_OP_WAIT 8'h8f
`define CPUXFR_OP_TSTA 8'h4d
`define CPUXFR_OP_TSTX 8'h5d
`define CPUXFR_OP_TSTD 8'h3d
`define CPUXFR_OP_TSTIX1 8'h6d
`define CPUXFR_OP_TSTIX 8'h7d
`define CPUXFR_OP_PRE 8'h9e
`define CPUXFR_OP_MOVDIX 8'h5e
`define CPUXFR_OP_MOVIMD 8'h6e
`define CPUXFR_OP_MOVIXD 8'h7e
`define CPUXFR_OP_CBEQIX1P 8'h61
`define CPUXFR_OP_LDAEXT 8'hc6
`define CPUXFR_OP_LDAIX2 8'hd6
`define CPUXFR_OP_BRSET0 8'h00
`define CPUXFR_BIT_V 7
`define CPUXFR_BIT_H 4
`define CPUXFR_BIT_I 3
`define CPUXFR_BIT_N 2
`define CPUXFR_BIT_Z 1
`define CPUXFR_BIT_C 0
`define CPUXFR_FLG_RST 8'h68
`define CPUXFR_SP_RST 16'h00ff
`define CPUXFR_TRAP_CYCLES 4'h9
`endif

// ===== rtl/cpuxfr_pkg.sv
// Types for the transfer, test and wait instruction core
package cpuxfr_pkg;
    typedef enum logic [7:0] {
        CPUXFR_FETCH = 8'h01,
        CPUXFR_OPND = 8'h02,
        CPUXFR_READ = 8'h04,
        CPUXFR_WRITE = 8'h08,
        CPUXFR_PUSH = 8'h10,
        CPUXFR_VEC = 8'h20,
        CPUXFR_HALT = 8'h40,
        CPUXFR_EXEC = 8'h80
    } cpuxfr_state_t;
endpackage

// ===== tb/cpuxfr_mem.sv
// Program and data memory model for the core bench
`timescale 1ns/10ps
`default_nettype none
module cpuxfr_mem (
    // Clock
    input wire logic sys_clk,
    // Memory bus
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    task automatic fill(input logic [7:0] v);
        for (int i = 0; i < 65536; i++) begin
            mem[i] = v;
        end
    endtask
    // Read answers in the strobe cycle; garbage otherwise so a late sample shows
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge sys_clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // cpuxfr_mem
`default_nettype wire

// ===== tb/cpuxfr_core_asserts.sv
// Assertion checker for the transfer, test and wait core
`timescale 1ns/10ps
`default_nettype none
module cpuxfr_core_asserts #(
    parameter logic [15:0] VECTOR_ADDR = 16'hfffc
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Memory bus
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Interrupt and status
    input wire logic irq_req,
    input wire logic halted,
    input wire logic [7:0] condition_code_register
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // Trap vector fetch
    sequence seq_vec_hi;
        mem_rd && mem_addr == VECTOR_ADDR;
    endsequence
    sequence seq_vec_lo;
        mem_rd && mem_addr == VECTOR_ADDR + 16'h0001;
    endsequence
    chk_vec_mask_set: assert property (seq_vec_hi |-> condition_code_register[3])
        else $error("mask clear at vector fetch");
    chk_vec_low_next: assert property (seq_vec_hi |-> ##[1:3] seq_vec_lo)
        else $error("vector low byte not fetched");
    // ==========================================
    // Wait halt
    chk_halt_mask_clr: assert property (halted |-> !condition_code_register[3])
        else $error("mask set while halted");
    chk_halt_flags_hold: assert property (halted ##1 halted |-> $stable(condition_code_register))
        else $error("flags moved while halted");
    chk_halt_no_bus: assert property (halted |-> !mem_rd && !mem_wr)
        else $error("bus active while halted");
    chk_halt_stay: assert property (halted && !irq_req |=> halted)
        else $error("halt left without request");
    chk_wake_fetch: assert property (halted && irq_req |-> ##[1:4] mem_rd)
        else $error("no fetch after wake");
    // ==========================================
    // Data moves
    chk_wdata_hold: assert property (!mem_wr && $past(resetn) |-> $stable(mem_wdata))
        else $error("write data moved without write");
    chk_rd_wr_excl: assert property (!(mem_rd && mem_wr))
        else $error("read and write together");
endmodule // cpuxfr_core_asserts
bind cpuxfr_core cpuxfr_core_asserts #(.VECTOR_ADDR(VECTOR_ADDR)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
    .halted(halted), .condition_code_register(condition_code_register));
`default_nettype wire

// ===== tb/cpuxfr_core_tb.sv
// Testbench for the transfer, test and wait core
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpuxfr_core_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic irq_req = 1'b0;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] flg_out;
    logic halted;
    int n_mismatch = 0;
    int tests_run = 0;
    always #2.5 sys_clk = ~sys_clk;
    cpuxfr_core #(.VECTOR_ADDR(16'hfffc)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .irq_req(irq_req), .halted(halted), .condition_code_register(flg_out));
    cpuxfr_mem u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    // ==========================================
    // Shared tasks
    task automatic stop_test;
        $display("counts: tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [7:0] m(input logic [15:0] a);
        return u_mem.mem[a];
    endfunction
    // Reset is held while the program is loaded, then released
    task automatic prog(input logic [7:0] p[$]);
        @(posedge sys_clk);
        resetn <= 1'b0;
        irq_req <= 1'b0;
        u_mem.fill(8'h9d);
        foreach (p[i]) u_mem.mem[i] = p[i];
        u_mem.mem[16'hfffc] = 8'h12;
        u_mem.mem[16'hfffd] = 8'h34;
    endtask
    task automatic go;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask
    task automatic wait_fetch(input logic [15:0] a);
        int i;
        for (i = 0; i < 200; i++) begin
            @(negedge sys_clk);
            if (mem_rd === 1'b1 && mem_addr === a) break;
        end
        if (i == 200) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, mem_addr, a);
            stop_test();
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_trap;
        prog('{8'hc6, 8'h02, 8'h00, 8'h97, 8'hc6, 8'h02, 8'h01, 8'h83});
        u_mem.mem[16'h0200] = 8'h5a;
        u_mem.mem[16'h0201] = 8'hc3;
        go();
        @(negedge sys_clk);
        `CHK(flg_out, 8'h68)
        `CHK(halted, 1'b0)
        wait_fetch(16'h1234);
        `CHK(m(16'h00ff), 8'h09)
        `CHK(m(16'h00fe), 8'h00)
        `CHK(m(16'h00fd), 8'h5a)
        `CHK(m(16'h00fc), 8'hc3)
        `CHK(m(16'h00fb), 8'h68)
        `CHK(flg_out[3], 1'b1)
        $display("test trap done");
    endtask
    task automatic t_halt;
        int i;
        prog('{8'hc6, 8'h02, 8'h00, 8'h84, 8'h4d, 8'h8f, 8'h85, 8'h97, 8'h83});
        u_mem.mem[16'h0200] = 8'hff;
        go();
        wait_fetch(16'h0005);
        `CHK(flg_out, 8'h7d)
        for (i = 0; i < 20 && halted !== 1'b1; i++) @(negedge sys_clk);
        `CHK(flg_out, 8'h75)
        repeat (10) @(negedge sys_clk);
        `CHK(halted, 1'b1)
        @(posedge sys_clk);
        irq_req <= 1'b1;
        wait_fetch(16'h0006);
        @(posedge sys_clk);
        irq_req <= 1'b0;
        @(negedge sys_clk);
        `CHK(halted, 1'b0)
        wait_fetch(16'h1234);
        `CHK(m(16'h00ff), 8'h0a)
        `CHK(m(16'h00fd), 8'h75)
        `CHK(m(16'h00fc), 8'h75)
        `CHK(m(16'h00fb), 8'h75)
        $display("test halt done");
    endtask
    task automatic t_move;
        prog('{8'h6e, 8'ha5, 8'h80, 8'h3d, 8'h80, 8'h95, 8'h5e, 8'h80, 8'h7e, 8'h90, 8'h94, 8'h83});
        u_mem.mem[16'h0101] = 8'h3c;
        go();
        wait_fetch(16'h0005);
        `CHK(flg_out, 8'h6c)
        `CHK(m(16'h0080), 8'ha5)
        wait_fetch(16'h000b);
        `CHK(m(16'h0100), 8'ha5)
        `CHK(m(16'h0090), 8'h3c)
        wait_fetch(16'h1234);
        `CHK(m(16'h0101), 8'h0d)
        `CHK(m(16'h00ff), 8'h02)
        `CHK(m(16'h00fd), 8'h6c)
        $display("test move done");
    endtask
    task automatic t_modes;
        prog('{8'h95, 8'hd6, 8'h01, 8'h00, 8'h9e, 8'h6d, 8'h10, 8'h61, 8'h02, 8'h03, 8'h9d, 8'h9d,
               8'h9d, 8'h00, 8'h80, 8'h02, 8'h83, 8'h83, 8'h94, 8'h83});
        u_mem.mem[16'h0200] = 8'h00;
        u_mem.mem[16'h0101] = 8'h55;
        u_mem.mem[16'h0102] = 8'h00;
        u_mem.mem[16'h010f] = 8'h80;
        u_mem.mem[16'h0080] = 8'h01;
        go();
        wait_fetch(16'h0007);
        `CHK(flg_out, 8'h6c)
        wait_fetch(16'h0012);
        wait_fetch(16'h1234);
        `CHK(m(16'h0100), 8'h15)
        `CHK(m(16'h00fe), 8'h01)
        `CHK(m(16'h00fd), 8'h00)
        $display("test modes done");
    endtask
    initial begin
        t_trap();
        t_halt();
        t_move();
        t_modes();
        stop_test();
    end
endmodule // cpuxfr_core_tb
`default_nettype wire
